// ==== hdl/control_mode_strap_decoder_defs.svh ====
// constants of the control-mode strap decoder: register offsets,
// field positions, reset values and bus widths.
// assumes inclusion by bare name from the design files under hdl/.
`ifndef CONTROL_MODE_STRAP_DECODER_DEFS_SVH
`define CONTROL_MODE_STRAP_DECODER_DEFS_SVH

// bus shape
`define CMS_ADDR_W 4
`define CMS_DATA_W 32

// byte offsets of the register words
`define CMS_OFS_CONFIG 4'h0
`define CMS_OFS_STATUS 4'h4
`define CMS_OFS_PINS 4'h8

// field positions shared by the config and status words
`define CMS_BIT_RANGE_RED 0
`define CMS_BIT_SWING_RED 1
`define CMS_BIT_EDGE_RISE 2
`define CMS_BIT_DDR 3
`define CMS_BIT_CAL_LONG 4
`define CMS_BIT_DES 5
`define CMS_CFG_W 6

// status word: mode flag position
`define CMS_BIT_EXT_MODE 8

// reset value of the config field: normal swing and range, rising edge
`define CMS_CFG_RESET 6'h04

// value of an unmapped read and of read data after reset
`define CMS_READ_ZERO 32'h0000_0000

// byte lane that carries the config field
`define CMS_LANE_CFG 0

// width of the packed pin snapshot: six pins of two bits each
`define CMS_PINS_W 12

`endif

// ==== hdl/control_mode_strap_pkg.sv ====
// types of the control-mode strap decoder.
// assumes the strap pins are already resolved into low/high/floating.
package control_mode_strap_pkg;

    // one three-level strap pin as resolved by the pad
    typedef struct packed {
        logic floating;
        logic high;
    } strap_pin_type;

    // function settings driven to the converter core
    typedef struct packed {
        logic dual_edge_sampling;
        logic calibration_delay_long;
        logic output_data_clock_ddr;
        logic output_edge_rising;
        logic output_swing_reduced;
        logic input_full_scale_reduced;
    } function_settings_type;

    // serial interface lines recovered from the shared pins
    typedef struct packed {
        logic serial_clock;
        logic serial_data_line;
        logic serial_select;
    } serial_lines_type;

endpackage

// ==== hdl/control_mode_strap_decoder.sv ====
// control-mode strap decoder: turns the resolved strap pins into the
// control mode, the converter's function settings and the serial lines,
// with an avalon-mm slave for settings and status.
// assumes all pin inputs are synchronous to clock and already resolved.
//
// Summary of operation
// R01: primary extended-control pin high forces the pin-programmed mode.
// R02: primary floating, secondary floating or high: full-scale pin decides mode.
// R03: extended mode when primary low, or primary floating with full-scale pin floating, secondary not low.
// R04: pin-programmed mode: serial lines idle, every function set from strap pins.
// R05: full-scale pin low gives reduced range, high gives normal range.
// R06: swing pin low gives reduced output swing, high gives normal swing.
// R07: edge pin high launches data on rising clock edge, low on falling.
// R08: edge pin floating makes the output data clock double data rate.
// R09: calibration pin low gives short delay, high gives long delay.
// R10: calibration pin floating gives short delay and dual edge sampling.
// R11: extended mode: swing, edge, calibration pins become serial clock, data, select.
// R12: each pin arrives as a resolved three-level input; decoding is combinational.
`timescale 1ns/1ps
`include "control_mode_strap_decoder_defs.svh"

module control_mode_strap_decoder (
    input wire logic clock,
    input wire logic rst,
    input wire control_mode_strap_pkg::strap_pin_type primary_ctrl_pin,
    input wire control_mode_strap_pkg::strap_pin_type secondary_ctrl_pin,
    input wire control_mode_strap_pkg::strap_pin_type full_scale_pin,
    input wire control_mode_strap_pkg::strap_pin_type swing_pin,
    input wire control_mode_strap_pkg::strap_pin_type edge_pin,
    input wire control_mode_strap_pkg::strap_pin_type cal_pin,
    input wire logic [`CMS_ADDR_W-1:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [`CMS_DATA_W-1:0] writedata,
    input wire logic [3:0] byteenable,
    output logic [`CMS_DATA_W-1:0] readdata,
    output logic waitrequest,
    output logic extended_mode,
    output control_mode_strap_pkg::function_settings_type settings,
    output control_mode_strap_pkg::serial_lines_type serial_lines
);

    // true when the secondary pin does not hold the decoder out of
    // extended control; a driven low keeps the pin-programmed mode
    function automatic logic secondary_allows(
        input control_mode_strap_pkg::strap_pin_type sec
    );
        secondary_allows = sec.floating | sec.high;
    endfunction

    function automatic logic is_low(
        input control_mode_strap_pkg::strap_pin_type p
    );
        is_low = !p.floating && !p.high;
    endfunction

    function automatic logic is_high(
        input control_mode_strap_pkg::strap_pin_type p
    );
        is_high = !p.floating && p.high;
    endfunction

    // mode decode from the three control straps; a driven-low secondary pin is
    // kept in pin-programmed mode so a stuck strap never opens the serial port
    function automatic logic decode_extended(
        input control_mode_strap_pkg::strap_pin_type prim,
        input control_mode_strap_pkg::strap_pin_type sec,
        input control_mode_strap_pkg::strap_pin_type fsr
    );
        logic ext;
        ext = 1'b0;
        if (is_high(prim)) begin
            ext = 1'b0; // R01
        end else if (!secondary_allows(sec)) begin
            ext = 1'b0;
        end else if (is_low(prim)) begin
            ext = 1'b1; // R03
        end else begin
            ext = fsr.floating; // R02 R03
        end
        decode_extended = ext;
    endfunction

    // function settings taken from the strap levels alone
    function automatic control_mode_strap_pkg::function_settings_type pin_settings(
        input control_mode_strap_pkg::strap_pin_type fsr,
        input control_mode_strap_pkg::strap_pin_type swg,
        input control_mode_strap_pkg::strap_pin_type edg,
        input control_mode_strap_pkg::strap_pin_type cal
    );
        control_mode_strap_pkg::function_settings_type s;
        s = '0;
        s.input_full_scale_reduced = !fsr.high; // R05
        s.output_swing_reduced = !swg.high; // R06
        // a floating edge pin makes the edge choice moot; keep rising
        s.output_data_clock_ddr = edg.floating; // R08
        s.output_edge_rising = edg.floating | edg.high; // R07
        // floating calibration pin shares the short delay of a low pin
        s.calibration_delay_long = is_high(cal); // R09 R10
        s.dual_edge_sampling = cal.floating; // R10
        pin_settings = s;
    endfunction

    // unpack the config field into settings
    function automatic control_mode_strap_pkg::function_settings_type cfg_settings(
        input logic [`CMS_CFG_W-1:0] cfg
    );
        control_mode_strap_pkg::function_settings_type s;
        s = '0;
        s.input_full_scale_reduced = cfg[`CMS_BIT_RANGE_RED];
        s.output_swing_reduced = cfg[`CMS_BIT_SWING_RED];
        s.output_edge_rising = cfg[`CMS_BIT_EDGE_RISE];
        s.output_data_clock_ddr = cfg[`CMS_BIT_DDR];
        s.calibration_delay_long = cfg[`CMS_BIT_CAL_LONG];
        s.dual_edge_sampling = cfg[`CMS_BIT_DES];
        cfg_settings = s;
    endfunction

    function automatic logic [`CMS_CFG_W-1:0] settings_bits(
        input control_mode_strap_pkg::function_settings_type s
    );
        logic [`CMS_CFG_W-1:0] b;
        b = '0;
        b[`CMS_BIT_RANGE_RED] = s.input_full_scale_reduced;
        b[`CMS_BIT_SWING_RED] = s.output_swing_reduced;
        b[`CMS_BIT_EDGE_RISE] = s.output_edge_rising;
        b[`CMS_BIT_DDR] = s.output_data_clock_ddr;
        b[`CMS_BIT_CAL_LONG] = s.calibration_delay_long;
        b[`CMS_BIT_DES] = s.dual_edge_sampling;
        settings_bits = b;
    endfunction

    logic ext_nxt;
    logic [`CMS_CFG_W-1:0] config_r;
    logic [`CMS_CFG_W-1:0] config_nxt;
    control_mode_strap_pkg::function_settings_type settings_nxt;
    control_mode_strap_pkg::serial_lines_type serial_nxt;
    logic [`CMS_DATA_W-1:0] read_word;
    logic bus_req;
    logic bus_take;

    // decoding is purely combinational from the resolved pin states and, in extended mode, config_r
    always_comb begin
        ext_nxt = decode_extended(primary_ctrl_pin, secondary_ctrl_pin,
            full_scale_pin); // R12
        if (ext_nxt) begin
            // shared pins belong to the serial port; settings come from
            // the software-held config that stands in for serial writes
            settings_nxt = cfg_settings(config_r);
            serial_nxt.serial_clock = swing_pin.high; // R11
            serial_nxt.serial_data_line = edge_pin.high; // R11
            serial_nxt.serial_select = cal_pin.high; // R11
        end else begin
            settings_nxt = pin_settings(full_scale_pin, swing_pin, edge_pin,
                cal_pin); // R04 R12
            serial_nxt = '0; // R04
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            extended_mode <= 1'b0;
            settings <= '0;
            serial_lines <= '0;
        end else begin
            extended_mode <= ext_nxt;
            settings <= settings_nxt;
            serial_lines <= serial_nxt;
        end
    end

    // avalon-mm slave: one wait cycle, then the request is taken at the
    // edge where waitrequest is seen low
    assign bus_req = read | write;
    assign bus_take = bus_req && !waitrequest;

    // the wait cycle lets readdata be registered; a master holding its request
    // past the take edge sees one more wait cycle, then a second take of the same request

    always_ff @(posedge clock) begin
        if (rst) begin
            waitrequest <= 1'b1;
        end else if (bus_req && waitrequest) begin
            waitrequest <= 1'b0;
        end else begin
            waitrequest <= 1'b1;
        end
    end

    // the pins word shows what the pads resolved, floating states included
    always_comb begin
        read_word = `CMS_READ_ZERO;
        unique case (address)
            `CMS_OFS_CONFIG: read_word[`CMS_CFG_W-1:0] = config_r;
            `CMS_OFS_STATUS: begin
                read_word[`CMS_CFG_W-1:0] = settings_bits(settings);
                read_word[`CMS_BIT_EXT_MODE] = extended_mode;
            end
            `CMS_OFS_PINS: read_word[`CMS_PINS_W-1:0] = {primary_ctrl_pin,
                secondary_ctrl_pin, full_scale_pin, swing_pin, edge_pin,
                cal_pin};
            default: read_word = `CMS_READ_ZERO;
        endcase
    end

    // read data is set up during the wait cycle and stands at the taking edge
    always_ff @(posedge clock) begin
        if (rst) begin
            readdata <= `CMS_READ_ZERO;
        end else if (read && waitrequest) begin
            readdata <= read_word;
        end
    end

    // only the config lane is writable; other lanes and offsets are ignored
    always_comb begin
        config_nxt = config_r;
        if (bus_take && write && address == `CMS_OFS_CONFIG
                && byteenable[`CMS_LANE_CFG]) begin
            config_nxt = writedata[`CMS_CFG_W-1:0];
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            config_r <= `CMS_CFG_RESET;
        end else begin
            config_r <= config_nxt;
        end
    end

    chk_primary_high_mode: assert property (@(posedge clock) disable iff (rst) // R01
        is_high(primary_ctrl_pin) |=> !extended_mode)
        else $error("primary pin high did not give pin-programmed mode");

    chk_fsr_decides_mode: assert property (@(posedge clock) disable iff (rst) // R02
        primary_ctrl_pin.floating && secondary_allows(secondary_ctrl_pin)
        |=> extended_mode == $past(full_scale_pin.floating))
        else $error("full-scale pin did not decide the mode");

    chk_primary_low_ext: assert property (@(posedge clock) disable iff (rst) // R03
        is_low(primary_ctrl_pin) && secondary_allows(secondary_ctrl_pin)
        |=> extended_mode)
        else $error("primary pin low did not give extended mode");

    chk_serial_idle_pin: assert property (@(posedge clock) disable iff (rst) // R04
        !extended_mode |-> serial_lines == '0)
        else $error("serial lines active in pin-programmed mode");

    chk_range_from_pin: assert property (@(posedge clock) disable iff (rst) // R05
        !ext_nxt |=> settings.input_full_scale_reduced == !$past(full_scale_pin.high))
        else $error("full-scale range does not follow its pin");

    chk_swing_from_pin: assert property (@(posedge clock) disable iff (rst) // R06
        !ext_nxt && !swing_pin.floating
        |=> settings.output_swing_reduced == !$past(swing_pin.high))
        else $error("output swing does not follow its pin");

    chk_edge_from_pin: assert property (@(posedge clock) disable iff (rst) // R07
        !ext_nxt && !edge_pin.floating
        |=> !settings.output_data_clock_ddr
            && settings.output_edge_rising == $past(edge_pin.high))
        else $error("output edge does not follow its pin");

    chk_ddr_on_float: assert property (@(posedge clock) disable iff (rst) // R08
        !ext_nxt && edge_pin.floating |=> settings.output_data_clock_ddr)
        else $error("floating edge pin did not give ddr clock");

    chk_cal_delay_pin: assert property (@(posedge clock) disable iff (rst) // R09
        !ext_nxt && !cal_pin.floating
        |=> settings.calibration_delay_long == $past(cal_pin.high)
            && !settings.dual_edge_sampling)
        else $error("calibration delay does not follow its pin");

    chk_cal_float_des: assert property (@(posedge clock) disable iff (rst) // R10
        !ext_nxt && cal_pin.floating
        |=> !settings.calibration_delay_long && settings.dual_edge_sampling)
        else $error("floating calibration pin did not give short delay and des");

    chk_serial_routing: assert property (@(posedge clock) disable iff (rst) // R11
        ext_nxt |=> serial_lines == {$past(swing_pin.high), $past(edge_pin.high),
            $past(cal_pin.high)})
        else $error("serial lines not routed from shared pins");

    chk_config_steers: assert property (@(posedge clock) disable iff (rst) // R12
        ext_nxt |=> settings_bits(settings) == $past(config_r))
        else $error("extended mode settings do not follow config");

    chk_wait_one_cycle: assert property (@(posedge clock) disable iff (rst)
        bus_req && waitrequest |=> !waitrequest ##1 waitrequest)
        else $error("waitrequest not low for exactly one cycle");

    // reset, secondary override, floating full-scale pin and the register bus
    chk_reset_outputs: assert property (@(posedge clock) // R04
        rst |=> waitrequest && !extended_mode && settings == '0 && serial_lines == '0
            && readdata == `CMS_READ_ZERO && config_r == `CMS_CFG_RESET)
        else $error("outputs not at reset values after reset");

    chk_secondary_low_pin: assert property (@(posedge clock) disable iff (rst) // R03
        is_low(secondary_ctrl_pin) |=> !extended_mode)
        else $error("secondary pin low did not keep pin-programmed mode");

    chk_fsr_float_ext: assert property (@(posedge clock) disable iff (rst) // R03
        full_scale_pin.floating && !is_high(primary_ctrl_pin)
            && secondary_allows(secondary_ctrl_pin)
        |=> extended_mode)
        else $error("floating full-scale pin did not give extended mode");

    chk_config_write: assert property (@(posedge clock) disable iff (rst)
        bus_take && write && address == `CMS_OFS_CONFIG && byteenable[`CMS_LANE_CFG]
        |=> config_r == $past(writedata[`CMS_CFG_W-1:0]))
        else $error("config write did not land");

    chk_config_hold: assert property (@(posedge clock) disable iff (rst)
        !(bus_take && write && address == `CMS_OFS_CONFIG && byteenable[`CMS_LANE_CFG])
        |=> $stable(config_r))
        else $error("config changed without a taken write");

    chk_read_config: assert property (@(posedge clock) disable iff (rst)
        read && waitrequest && address == `CMS_OFS_CONFIG
        |=> readdata[`CMS_CFG_W-1:0] == $past(config_r))
        else $error("config read data wrong");

    chk_read_status: assert property (@(posedge clock) disable iff (rst)
        read && waitrequest && address == `CMS_OFS_STATUS
        |=> readdata[`CMS_BIT_EXT_MODE] == $past(extended_mode))
        else $error("status read does not show the mode");

    chk_read_unmapped: assert property (@(posedge clock) disable iff (rst)
        read && waitrequest && address != `CMS_OFS_CONFIG && address != `CMS_OFS_STATUS
            && address != `CMS_OFS_PINS |=> readdata == `CMS_READ_ZERO)
        else $error("unmapped read did not return zero");

    chk_pins_read: assert property (@(posedge clock) disable iff (rst) // R12
        read && waitrequest && address == `CMS_OFS_PINS
        |=> readdata[`CMS_PINS_W-1:0] == $past({primary_ctrl_pin, secondary_ctrl_pin,
            full_scale_pin, swing_pin, edge_pin, cal_pin}))
        else $error("pins word does not show the resolved pins");

    chk_readdata_hold: assert property (@(posedge clock) disable iff (rst)
        !(read && waitrequest) |=> $stable(readdata))
        else $error("readdata changed outside a read");

    chk_wait_idle_high: assert property (@(posedge clock) disable iff (rst)
        !bus_req |=> waitrequest)
        else $error("waitrequest low without a request");

endmodule

// ==== verif/strap_board_model.sv ====
// partner model: board strap wiring plus a host serial controller on the shared pins.
// assumes the bench sets strap levels and host lines just after a rising edge.
`timescale 1ns/1ps

module strap_board_model (
    input wire logic [11:0] strap_set,
    input wire logic host_en,
    input wire logic [2:0] host_lines,
    output control_mode_strap_pkg::strap_pin_type prim,
    output control_mode_strap_pkg::strap_pin_type sec,
    output control_mode_strap_pkg::strap_pin_type fsr,
    output control_mode_strap_pkg::strap_pin_type swing,
    output control_mode_strap_pkg::strap_pin_type edg,
    output control_mode_strap_pkg::strap_pin_type cal
);
    // each pin is a resolved {floating,high} pair, never a raw analog level
    assign prim = strap_set[11:10];
    assign sec = strap_set[9:8];
    assign fsr = strap_set[7:6];
    // the host owns the shared pins only while it runs the serial interface
    assign swing = host_en ? {1'b0, host_lines[2]} : strap_set[5:4];
    assign edg = host_en ? {1'b0, host_lines[1]} : strap_set[3:2];
    assign cal = host_en ? {1'b0, host_lines[0]} : strap_set[1:0];
endmodule

// ==== verif/control_mode_strap_decoder_test.sv ====
// self-checking bench: strap tables and avalon accesses against worked expectations.
// assumes the design and its defs header are compiled with hdl/ on the include path.
`timescale 1ns/1ps
`include "control_mode_strap_decoder_defs.svh"

module control_mode_strap_decoder_test;
    logic clock;
    logic rst;
    logic [11:0] strap_set;
    logic host_en;
    logic [2:0] host_lines;
    logic [3:0] address;
    logic read;
    logic write;
    logic [31:0] writedata;
    logic [3:0] byteenable;
    logic [31:0] readdata;
    logic waitrequest;
    logic extended_mode;
    control_mode_strap_pkg::function_settings_type settings;
    control_mode_strap_pkg::serial_lines_type serial_lines;
    control_mode_strap_pkg::strap_pin_type prim, sec, fsr, swing, edg, cal;
    int n_errors;
    int compares;
    logic [31:0] q;
    logic [9:0] e;
    logic [11:0] cases [8];

    strap_board_model board (.strap_set(strap_set), .host_en(host_en),
        .host_lines(host_lines), .prim(prim), .sec(sec), .fsr(fsr), .swing(swing),
        .edg(edg), .cal(cal));

    control_mode_strap_decoder dut (.clock(clock), .rst(rst), .primary_ctrl_pin(prim),
        .secondary_ctrl_pin(sec), .full_scale_pin(fsr), .swing_pin(swing), .edge_pin(edg),
        .cal_pin(cal), .address(address), .read(read), .write(write),
        .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
        .waitrequest(waitrequest), .extended_mode(extended_mode), .settings(settings),
        .serial_lines(serial_lines));

    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end

    // {extended, six settings, three serial lines}; pin order as in the pins word
    function automatic logic [9:0] expect_out(input logic [11:0] p, input logic [5:0] cfg);
        logic ext;
        logic [5:0] s;
        ext = (p[9] | p[8]) & ((~p[11] & ~p[10]) | (p[11] & p[7]));
        s = {p[1], ~p[1] & p[0], p[3], p[3] | p[2], ~p[4], p[7] | ~p[6]};
        return ext ? {1'b1, cfg, ~p[5] & p[4], ~p[3] & p[2], ~p[1] & p[0]} : {1'b0, s, 3'b000};
    endfunction

    task automatic close_out();
        $display("compares %0d n_errors %0d", compares, n_errors);
        if (n_errors == 0 && compares > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            n_errors++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask

    // one avalon access; read data land in q at the edge where waitrequest is seen low
    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d,
            input logic [3:0] be);
        int n;
        @(posedge clock);
        address <= a;
        write <= wr;
        read <= ~wr;
        writedata <= d;
        byteenable <= be;
        n = 0;
        do begin
            @(posedge clock);
            n++;
        end while (waitrequest !== 1'b0 && n < 20);
        q = readdata;
        read <= 1'b0;
        write <= 1'b0;
        if (waitrequest !== 1'b0) begin
            n_errors++;
            $display("MISMATCH waitrequest expected 0 seen %b", waitrequest);
            close_out();
        end
    endtask

    task automatic apply(input logic [11:0] p);
        @(posedge clock);
        strap_set <= p;
        @(posedge clock);
        @(negedge clock);
    endtask

    initial begin
        rst = 1'b1;
        read = 1'b0;
        write = 1'b0;
        address = 4'h0;
        writedata = 32'h0;
        byteenable = 4'h0;
        host_en = 1'b0;
        host_lines = 3'h0;
        strap_set = 12'h605;
        n_errors = 0;
        compares = 0;
        cases = '{12'h605, 12'h950, 12'hA91, 12'h144, 12'h55A, 12'h011, 12'h892, 12'hA08};
        repeat (2) @(posedge clock);
        rst <= 1'b0;
        bus(1'b0, `CMS_OFS_CONFIG, 32'h0, 4'hF);
        check("config reset", 32'h4, q);
        bus(1'b1, `CMS_OFS_CONFIG, 32'h3F, 4'h0);
        bus(1'b1, `CMS_OFS_STATUS, 32'hFF, 4'hF);
        bus(1'b0, `CMS_OFS_CONFIG, 32'h0, 4'hF);
        check("config kept", 32'h4, q);
        bus(1'b1, `CMS_OFS_CONFIG, 32'h2A, 4'h1);
        bus(1'b0, `CMS_OFS_CONFIG, 32'h0, 4'hF);
        check("config written", 32'h2A, q);
        bus(1'b0, 4'hC, 32'h0, 4'hF);
        check("unmapped read", 32'h0, q);
        for (int i = 0; i < 8; i++) begin
            apply(cases[i]);
            e = expect_out(cases[i], 6'h2A);
            check("outputs", {22'h0, e}, {22'h0, extended_mode, settings, serial_lines});
            bus(1'b0, `CMS_OFS_STATUS, 32'h0, 4'hF);
            check("status", {23'h0, e[9], 2'b00, e[8:3]}, q);
            bus(1'b0, `CMS_OFS_PINS, 32'h0, 4'hF);
            check("pins", {20'h0, cases[i]}, q);
        end
        apply(12'h144);
        for (int i = 0; i < 8; i++) begin
            @(posedge clock);
            host_en <= 1'b1;
            host_lines <= i[2:0];
            @(posedge clock);
            @(negedge clock);
            check("serial lines", {29'h0, i[2:0]}, {29'h0, serial_lines});
            check("extended held", 32'h1, {31'h0, extended_mode});
        end
        // reset in mid-run from extended mode with live serial lines
        @(posedge clock);
        host_en <= 1'b0;
        rst <= 1'b1;
        repeat (2) @(posedge clock);
        @(negedge clock);
        check("reset outputs", 32'h0, {22'h0, extended_mode, settings, serial_lines});
        check("reset waitrequest", 32'h1, {31'h0, waitrequest});
        check("reset readdata", 32'h0, readdata);
        @(posedge clock);
        rst <= 1'b0;
        bus(1'b0, `CMS_OFS_CONFIG, 32'h0, 4'hF);
        check("config after reset", {26'h0, `CMS_CFG_RESET}, q);
        e = expect_out(12'h144, `CMS_CFG_RESET);
        check("outputs after reset", {22'h0, e}, {22'h0, extended_mode, settings, serial_lines});
        close_out();
    end
endmodule
